// ### logic/cmc_map.svh
`ifndef CMC_MAP_SVH
`define CMC_MAP_SVH

// Register indices on the byte-wide register port.
`define CMC_ADDR_MODE        8'h00
`define CMC_ADDR_CMD         8'h01
`define CMC_ADDR_STATUS      8'h1F

// Mode control field positions.
`define CMC_MOD_LOOPBACK     7
`define CMC_MOD_RSVD_SIX     6
`define CMC_MOD_POLARITY     5
`define CMC_MOD_SLEEP        4
`define CMC_MOD_RSVD_THREE   3
`define CMC_MOD_SELF_TEST    2
`define CMC_MOD_LISTEN_ONLY  1
`define CMC_MOD_RESET_MODE   0

// Command strobe field positions; bits 7 to 5 do nothing.
`define CMC_CMD_SELF_RX      4
`define CMC_CMD_CLR_OVERRUN  3
`define CMC_CMD_RELEASE      2
`define CMC_CMD_ABORT        1
`define CMC_CMD_TX_REQ       0

// Status field positions of the local status register.
`define CMC_ST_OVERRUN       0
`define CMC_ST_BUS_ON        1
`define CMC_ST_ASLEEP        2
`define CMC_ST_RX_LOCKED     3
`define CMC_ST_BUSOFF_CAUSE  4

// Reset value of mode control: only reset mode set.
`define CMC_MODE_RESET_VAL   8'h01

// Recessive bits in one bus-free sequence.
`define CMC_BUS_FREE_BITS    4'hB
// Bus-free sequences needed after bus-off.
`define CMC_BUSOFF_SEQS      8'h80
// Cycles after a release before the receive side may update.
`define CMC_RELEASE_GAP      2'h2

`endif

// ### logic/cmc_pkg.sv
package cmc_pkg;

    // Sleep state machine, one-hot.
    typedef enum logic [2:0] {
        CMC_AWAKE     = 3'h1,
        CMC_ASLEEP    = 3'h2,
        CMC_RX_LOCKED = 3'h4
    } cmc_sleep_e;

    typedef logic [7:0] cmc_byte_t;

endpackage

// ### logic/cmc_mode_ctrl.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
`include "cmc_map.svh"
// Overview of operation
// - Loopback copies receive pin to transmit pin.
// - Loopback ignores receive polarity.
// - Polarity bit selects which level is dominant.
// - Reserved mode bits read back zero.
// - Sleep only if requested, no interrupt, quiet.
// - Sleep refused by busy state raises wake-up.
// - Wake on clear or activity, raise wake-up.
// - After activity wake, wait eleven recessive bits.
// - No sleep in reset mode, nor before bus-free.
// - Self test succeeds without acknowledge.
// - Listen-only: no ack, no flags, counters hold.
// - Listen-only is error passive, never transmits.
// - Protected mode bits written only in reset.
// - Reset mode aborts frames; clearing resumes operation.
// - Hardware reset and bus-off set reset mode.
// - Bus-on after one or 128 bus-free sequences.
// - Command register write-only, top three reserved.
// - Self reception transmits and receives together.
// - Clear overrun command clears overrun flag.
// - Release command frees current receive message.
// - Abort cancels a pending, unstarted transmission.
// - Transmit request sends the buffered message.
// - Request with abort means single shot.
// - Two cycles after release before receive update.
module cmc_mode_ctrl
    import cmc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              CLK_I,
    input  wire logic              RSTN_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [7:0]        WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [7:0]        RDATA_O,
    input  wire logic              BUS_RX_PIN_I,
    output logic                   BUS_TX_PIN_O,
    input  wire logic              CORE_TXD_I,
    input  wire logic              BIT_TICK_I,
    input  wire logic              BUS_OFF_I,
    input  wire logic              IRQ_PENDING_I,
    input  wire logic              FRAME_DONE_I,
    input  wire logic              ACK_SEEN_I,
    input  wire logic              OVERRUN_I,
    output logic                   RX_DOMINANT_O,
    output logic                   RESET_MODE_O,
    output logic                   BUS_ON_O,
    output logic                   RX_ENABLE_O,
    output logic                   SLEEP_O,
    output logic                   WAKE_IRQ_O,
    output logic                   ACK_ENABLE_O,
    output logic                   ERR_FLAG_ENABLE_O,
    output logic                   ERR_COUNT_HOLD_O,
    output logic                   TX_ALLOW_O,
    output logic                   TX_OK_O,
    output logic                   TX_REQ_O,
    output logic                   SELF_RX_O,
    output logic                   SINGLE_SHOT_O,
    output logic                   ABORT_O,
    output logic                   RELEASE_O,
    output logic                   RX_UPDATE_OK_O
);

    // Decoded register strobes.
    logic       wr_mode;      // Write to mode control.
    logic       wr_cmd;       // Write to command strobe.
    logic       rd_mode;      // Read of mode control.
    logic       rd_status;    // Read of local status.
    // Stored mode bits.
    logic       loopback_test_bit;
    logic       rx_polarity_bit;
    logic       sleep_request_bit;
    logic       self_test_bit;
    logic       listen_only_bit;
    logic       reset_mode_bit;
    // Bus observation.
    logic       rx_dom;       // Receive pin seen as dominant.
    logic [3:0] recessive_cnt_reg;
    logic       bus_free_reg; // One-cycle pulse per bus-free sequence.
    logic       free_seen_reg;// Bus-free seen since reset mode left.
    // Bus-on recovery.
    logic       busoff_cause_reg;
    logic       bus_off_d_reg;
    logic [7:0] seq_left_reg;
    // Sleep control.
    cmc_sleep_e sleep_state_reg;
    logic       sleep_refused;// Sleep request meets a busy controller.
    // Command release gap and overrun flag.
    logic [1:0] gap_cnt_reg;
    logic       overrun_reg;
    logic       cmd_tx;       // Any request to send.
    // Typed copy of the reset value, so that one bit of it can be picked.
    localparam cmc_byte_t mode_rst_val = `CMC_MODE_RESET_VAL;

    // Register address decode, shared by reads and writes.
    function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                     input logic [7:0]        idx);
        return a == ADDR_W'(idx);
    endfunction

    assign wr_mode   = WR_I && addr_is(ADDR_I, `CMC_ADDR_MODE);
    assign wr_cmd    = WR_I && addr_is(ADDR_I, `CMC_ADDR_CMD);
    assign rd_mode   = RD_I && addr_is(ADDR_I, `CMC_ADDR_MODE);
    assign rd_status = RD_I && addr_is(ADDR_I, `CMC_ADDR_STATUS);
    // Polarity: dominant is high when the bit is one, low otherwise.
    assign rx_dom    = rx_polarity_bit ? BUS_RX_PIN_I
                                       : !BUS_RX_PIN_I;
    assign cmd_tx    = WDATA_I[`CMC_CMD_TX_REQ] ||
                       WDATA_I[`CMC_CMD_SELF_RX];
    // A sleep request while work is pending is turned into a wake-up.
    assign sleep_refused = IRQ_PENDING_I || rx_dom;

    // Protected mode bits take a write only if reset mode already held.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            loopback_test_bit <= 1'b0;
            rx_polarity_bit   <= 1'b0;
            self_test_bit     <= 1'b0;
            listen_only_bit   <= 1'b0;
        end else if (wr_mode && reset_mode_bit) begin
            // Bit six is accepted but has no function and reads zero.
            loopback_test_bit <= WDATA_I[`CMC_MOD_LOOPBACK];
            rx_polarity_bit   <= WDATA_I[`CMC_MOD_POLARITY];
            self_test_bit     <= WDATA_I[`CMC_MOD_SELF_TEST];
            listen_only_bit   <= WDATA_I[`CMC_MOD_LISTEN_ONLY];
        end
    end

    // Reset mode: set by hardware reset and a new bus-off, else as written.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            reset_mode_bit <= mode_rst_val[`CMC_MOD_RESET_MODE];
        end else if (BUS_OFF_I && !bus_off_d_reg) begin
            // Bus-off wins over a simultaneous software clear.
            reset_mode_bit <= 1'b1;
        end else if (wr_mode) begin
            reset_mode_bit <= WDATA_I[`CMC_MOD_RESET_MODE];
        end
    end

    // Remember what put the block into reset mode.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bus_off_d_reg    <= 1'b0;
            busoff_cause_reg <= 1'b0;
        end else begin
            bus_off_d_reg <= BUS_OFF_I;
            if (BUS_OFF_I && !bus_off_d_reg) begin
                busoff_cause_reg <= 1'b1;
            end else if (wr_mode && WDATA_I[`CMC_MOD_RESET_MODE] &&
                         !reset_mode_bit) begin
                // A software-initiated reset needs only one sequence.
                busoff_cause_reg <= 1'b0;
            end
        end
    end

    // Count recessive bits at each bit tick; eleven make a bus-free.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            recessive_cnt_reg <= 4'h0;
            bus_free_reg      <= 1'b0;
        end else begin
            bus_free_reg <= 1'b0;
            if (BIT_TICK_I) begin
                if (rx_dom) begin
                    recessive_cnt_reg <= 4'h0;
                end else if (recessive_cnt_reg ==
                             `CMC_BUS_FREE_BITS - 4'h1) begin
                    recessive_cnt_reg <= 4'h0;
                    bus_free_reg      <= 1'b1;
                end else begin
                    recessive_cnt_reg <= recessive_cnt_reg + 4'h1;
                end
            end
        end
    end

    // Bus-on recovery: armed while in reset mode, counts sequences after.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            seq_left_reg <= 8'h01;
            BUS_ON_O     <= 1'b0;
        end else if (reset_mode_bit) begin
            // Reload the wait for the cause that is in force now.
            seq_left_reg <= busoff_cause_reg ? `CMC_BUSOFF_SEQS
                                             : 8'h01;
            BUS_ON_O     <= 1'b0;
        end else if (!BUS_ON_O && bus_free_reg) begin
            seq_left_reg <= seq_left_reg - 8'h01;
            BUS_ON_O     <= (seq_left_reg == 8'h01);
        end
    end

    // Sleep is allowed only after a bus-free outside reset mode.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            free_seen_reg <= 1'b0;
        end else if (reset_mode_bit) begin
            free_seen_reg <= 1'b0;
        end else if (bus_free_reg) begin
            free_seen_reg <= 1'b1;
        end
    end

    // Sleep request bit and sleep state machine.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sleep_request_bit <= 1'b0;
            sleep_state_reg   <= CMC_AWAKE;
            WAKE_IRQ_O        <= 1'b0;
        end else begin
            WAKE_IRQ_O <= 1'b0;
            if (wr_mode) begin
                // Refused in reset mode and until bus-free is seen.
                sleep_request_bit <= WDATA_I[`CMC_MOD_SLEEP] &&
                                     !reset_mode_bit &&
                                     free_seen_reg;
            end
            case (sleep_state_reg)
                CMC_AWAKE: begin
                    if (sleep_request_bit && !reset_mode_bit) begin
                        if (sleep_refused) begin
                            sleep_request_bit <= 1'b0;
                            WAKE_IRQ_O        <= 1'b1;
                        end else begin
                            sleep_state_reg <= CMC_ASLEEP;
                        end
                    end
                end
                CMC_ASLEEP: begin
                    if (rx_dom) begin
                        // Activity wakes us mid-frame: that frame is lost.
                        sleep_request_bit <= 1'b0;
                        WAKE_IRQ_O        <= 1'b1;
                        sleep_state_reg   <= CMC_RX_LOCKED;
                    end else if (!sleep_request_bit || reset_mode_bit) begin
                        WAKE_IRQ_O      <= 1'b1;
                        sleep_state_reg <= CMC_AWAKE;
                    end
                end
                CMC_RX_LOCKED: begin
                    if (bus_free_reg) begin
                        sleep_state_reg <= CMC_AWAKE;
                    end
                end
                default: begin
                    sleep_state_reg <= CMC_AWAKE;
                end
            endcase
        end
    end

    // Transmit pin: loopback mirrors the raw pin, polarity not applied.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            BUS_TX_PIN_O <= 1'b1;
        end else if (loopback_test_bit) begin
            BUS_TX_PIN_O <= BUS_RX_PIN_I;
        end else begin
            BUS_TX_PIN_O <= CORE_TXD_I;
        end
    end

    // Mode levels towards the protocol engine.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RX_DOMINANT_O     <= 1'b0;
            RESET_MODE_O      <= 1'b1;
            RX_ENABLE_O       <= 1'b0;
            SLEEP_O           <= 1'b0;
            ACK_ENABLE_O      <= 1'b0;
            ERR_FLAG_ENABLE_O <= 1'b0;
            ERR_COUNT_HOLD_O  <= 1'b1;
            TX_ALLOW_O        <= 1'b0;
        end else begin
            RX_DOMINANT_O     <= rx_dom;
            // Reset mode aborts any frame in flight.
            RESET_MODE_O      <= reset_mode_bit;
            RX_ENABLE_O       <= BUS_ON_O && !reset_mode_bit &&
                                 sleep_state_reg == CMC_AWAKE;
            SLEEP_O           <= sleep_state_reg == CMC_ASLEEP;
            ACK_ENABLE_O      <= !listen_only_bit;
            // Listen-only acts as error passive: no active flags.
            ERR_FLAG_ENABLE_O <= !listen_only_bit;
            ERR_COUNT_HOLD_O  <= listen_only_bit || reset_mode_bit;
            TX_ALLOW_O        <= !listen_only_bit && BUS_ON_O &&
                                 !reset_mode_bit;
        end
    end

    // Success needs an acknowledge unless self test is on.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            TX_OK_O <= 1'b0;
        end else begin
            TX_OK_O <= FRAME_DONE_I &&
                       (ACK_SEEN_I || self_test_bit);
        end
    end

    // Commands become one-cycle pulses; nothing is stored.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            TX_REQ_O      <= 1'b0;
            SELF_RX_O     <= 1'b0;
            SINGLE_SHOT_O <= 1'b0;
            ABORT_O       <= 1'b0;
            RELEASE_O     <= 1'b0;
        end else begin
            // Listen-only drops send requests altogether.
            TX_REQ_O      <= wr_cmd && cmd_tx &&
                             !listen_only_bit;
            // Self reception is ignored when a plain request comes too.
            SELF_RX_O     <= wr_cmd && !listen_only_bit &&
                             WDATA_I[`CMC_CMD_SELF_RX] &&
                             !WDATA_I[`CMC_CMD_TX_REQ];
            SINGLE_SHOT_O <= wr_cmd && cmd_tx && !listen_only_bit &&
                             WDATA_I[`CMC_CMD_ABORT];
            // The engine drops the abort once the frame has started.
            ABORT_O       <= wr_cmd && WDATA_I[`CMC_CMD_ABORT] &&
                             !cmd_tx;
            RELEASE_O     <= wr_cmd && WDATA_I[`CMC_CMD_RELEASE];
        end
    end

    // Release gap: receive side may not update for two cycles.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            gap_cnt_reg    <= 2'h0;
            RX_UPDATE_OK_O <= 1'b1;
        end else begin
            if (wr_cmd && WDATA_I[`CMC_CMD_RELEASE]) begin
                gap_cnt_reg <= `CMC_RELEASE_GAP;
            end else if (gap_cnt_reg != 2'h0) begin
                gap_cnt_reg <= gap_cnt_reg - 2'h1;
            end
            RX_UPDATE_OK_O <= !(wr_cmd && WDATA_I[`CMC_CMD_RELEASE]) &&
                              gap_cnt_reg <= 2'h1;
        end
    end

    // Overrun flag: a new overrun wins over a clear in the same cycle.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            overrun_reg <= 1'b0;
        end else if (OVERRUN_I) begin
            overrun_reg <= 1'b1;
        end else if (wr_cmd && WDATA_I[`CMC_CMD_CLR_OVERRUN]) begin
            overrun_reg <= 1'b0;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            RDATA_O <= 8'h00;
        end else if (rd_mode) begin
            // Reserved bits six and three always read zero.
            RDATA_O <= {loopback_test_bit, 1'b0, rx_polarity_bit,
                        sleep_request_bit, 1'b0, self_test_bit,
                        listen_only_bit, reset_mode_bit};
        end else if (rd_status) begin
            RDATA_O <= {3'h0, busoff_cause_reg,
                        sleep_state_reg == CMC_RX_LOCKED,
                        sleep_state_reg == CMC_ASLEEP,
                        BUS_ON_O, overrun_reg};
        end else begin
            // Command strobe is write-only and reads zero.
            RDATA_O <= 8'h00;
        end
    end

    // Two sequences: a release, and the receive hold starting in that same cycle.
    sequence s_release;
        $rose(RELEASE_O);
    endsequence
    sequence s_hold_two;
        !RX_UPDATE_OK_O [*2];
    endsequence

    chk_loopback_mirror: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        loopback_test_bit |=> BUS_TX_PIN_O == $past(BUS_RX_PIN_I))
        else $error("Transmit pin does not mirror receive pin.");

    chk_rx_polarity: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        ##1 RX_DOMINANT_O == ($past(rx_polarity_bit) ?
            $past(BUS_RX_PIN_I) : !$past(BUS_RX_PIN_I)))
        else $error("Dominant level does not follow polarity.");

    chk_reserved_zero: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        rd_mode |=> RDATA_O[6] == 1'b0 && RDATA_O[3] == 1'b0)
        else $error("Reserved mode bit read as one.");

    chk_sleep_refused: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        wr_mode && reset_mode_bit |=> !sleep_request_bit)
        else $error("Sleep accepted in reset mode.");

    chk_mode_protect: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        wr_mode && !reset_mode_bit |=>
            $stable(listen_only_bit) && $stable(loopback_test_bit))
        else $error("Protected mode bit changed outside reset.");

    chk_busoff_reset: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        $rose(BUS_OFF_I) |=> reset_mode_bit ##1 RESET_MODE_O)
        else $error("Bus-off did not enter reset mode.");

    chk_cmd_pulse: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        !wr_cmd |=> !TX_REQ_O && !ABORT_O && !RELEASE_O)
        else $error("Command output without a command write.");

    chk_single_shot: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        wr_cmd && WDATA_I[0] && WDATA_I[1] && !listen_only_bit |=>
            TX_REQ_O && SINGLE_SHOT_O && !ABORT_O)
        else $error("Request with abort is not single shot.");

    chk_release_gap: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        s_release |-> s_hold_two)
        else $error("Receive update too soon after release.");

    chk_wake_activity: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        sleep_state_reg == CMC_ASLEEP && rx_dom |=>
            WAKE_IRQ_O && sleep_state_reg == CMC_RX_LOCKED)
        else $error("Bus activity did not wake the controller.");

    chk_self_test_ok: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        FRAME_DONE_I && !ACK_SEEN_I |=> TX_OK_O == $past(self_test_bit))
        else $error("Unacknowledged success wrong for mode.");

    chk_listen_no_tx: assert property (
        @(posedge CLK_I) disable iff (!RSTN_I)
        listen_only_bit |=> !TX_ALLOW_O && !ACK_ENABLE_O)
        else $error("Listen-only still allows transmit or ack.");

endmodule

// ### dv/cmc_bus_model.sv
`timescale 1ns/100ps
// Behavioural stand-in for the transceiver and the other nodes on the bus.
module cmc_bus_model #(
    parameter int BIT_CYC = 2 // Clock cycles per bus bit, kept short.
) (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic dom_i,
    input  wire logic pol_i,
    output logic      rx_o,
    output logic      tick_o
);
    int cnt; // Divider that marks each bit sample point.
    // Some node drives dominant, else the bus rests recessive.
    // The transceiver level of dominant follows pol_i.
    assign rx_o = dom_i ? pol_i : ~pol_i;
    // Sample point pulses run free, as the bus bit time never stops.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
        end
    end
    assign tick_o = (cnt == BIT_CYC - 1);
endmodule

// ### dv/tb.sv
`timescale 1ns/100ps
module tb;
    logic       clk, rstn, wr, rd, ctxd, boff, irq, fdone, ack, ovr;
    logic       dom, pol, rx, tick, txp, rxd, rmode, bon, rxen, slp;
    logic       wirq, acken, erren, hold, txal, txok, txrq, srx;
    logic       sshot, abrt, rel, upok;
    logic [7:0] addr, wdata, rdata;
    int         fails, n_tests;
    // Command bytes and the pulses each must produce.
    logic [7:0] cw [9] = '{8'h01, 8'h10, 8'h03, 8'h12, 8'h11, 8'h02,
                           8'h04, 8'hE0, 8'h08};
    logic [4:0] ce [9] = '{5'h10, 5'h18, 5'h14, 5'h1C, 5'h10, 5'h02,
                           5'h01, 5'h00, 5'h00};
    cmc_bus_model u_bus (.clk_i(clk), .rstn_i(rstn), .dom_i(dom),
                         .pol_i(pol), .rx_o(rx), .tick_o(tick));
    cmc_mode_ctrl u_dut (
        .CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BUS_RX_PIN_I(rx),
        .BUS_TX_PIN_O(txp), .CORE_TXD_I(ctxd), .BIT_TICK_I(tick),
        .BUS_OFF_I(boff), .IRQ_PENDING_I(irq), .FRAME_DONE_I(fdone),
        .ACK_SEEN_I(ack), .OVERRUN_I(ovr), .RX_DOMINANT_O(rxd),
        .RESET_MODE_O(rmode), .BUS_ON_O(bon), .RX_ENABLE_O(rxen),
        .SLEEP_O(slp), .WAKE_IRQ_O(wirq), .ACK_ENABLE_O(acken),
        .ERR_FLAG_ENABLE_O(erren), .ERR_COUNT_HOLD_O(hold),
        .TX_ALLOW_O(txal), .TX_OK_O(txok), .TX_REQ_O(txrq),
        .SELF_RX_O(srx), .SINGLE_SHOT_O(sshot), .ABORT_O(abrt),
        .RELEASE_O(rel), .RX_UPDATE_OK_O(upok));
    // Every check lands here, so the counts stay in one place.
    task automatic ck(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic c1(input logic g, input logic e);
        ck({7'h00, g}, {7'h00, e});
    endtask
    // Sampling a little after the edge keeps clear of update races.
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk) wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) rd <= 1'b1;
        addr <= a;
        @(posedge clk) rd <= 1'b0;
        #1;
        ck(rdata, e);
    endtask
    task automatic frame(input logic a);
        @(posedge clk) fdone <= 1'b1;
        ack <= a;
        @(posedge clk) fdone <= 1'b0;
        #1;
    endtask
    // Bus-free needs eleven recessive bits, so allow plenty of room.
    task automatic w_on();
        for (int i = 0; i < 200 && bon !== 1'b1; i++) cyc(1);
        c1(bon, 1'b1);
    endtask
    task automatic t_reg();
        ck({5'h00, txp, rmode, hold}, 8'h07);
        rd8(8'h00, 8'h01);
        rd8(8'h01, 8'h00);
        rd8(8'h10, 8'h00);
        wr8(8'h00, 8'hFF);
        rd8(8'h00, 8'hA7);
    endtask
    // Loopback must copy the raw pin whatever the polarity bit says.
    task automatic t_loop();
        for (int p = 0; p < 2; p++) begin
            wr8(8'h00, p ? 8'hA1 : 8'h81);
            for (int d = 0; d < 2; d++) begin
                @(posedge clk) dom <= d[0];
                ctxd <= d[0];
                cyc(3);
                c1(txp, ~d[0]);
            end
        end
        wr8(8'h00, 8'h01);
        cyc(2);
        c1(txp, 1'b1);
    endtask
    task automatic t_pol();
        for (int p = 1; p >= 0; p--) begin
            wr8(8'h00, {2'b00, p[0], 5'h01});
            @(posedge clk) pol <= p[0];
            for (int d = 0; d < 2; d++) begin
                @(posedge clk) dom <= d[0];
                cyc(3);
                c1(rxd, d[0]);
            end
        end
        @(posedge clk) dom <= 1'b0;
    endtask
    task automatic t_cmd();
        wr8(8'h00, 8'h00);
        wr8(8'h00, 8'hA6);
        rd8(8'h00, 8'h00);
        w_on();
        cyc(1);
        ck({acken, erren, hold, txal}, 8'h0D);
        for (int i = 0; i < 9; i++) begin
            wr8(8'h01, cw[i]);
            ck({txrq, srx, sshot, abrt, rel}, ce[i]);
            ck({txrq, srx, sshot, abrt, rel}, ce[i]);
            cyc(1);
            ck({txrq, srx, sshot, abrt, rel}, 8'h00);
        end
        wr8(8'h01, 8'h04);
        c1(upok, 1'b0);
        cyc(1);
        c1(upok, 1'b0);
        cyc(1);
        c1(upok, 1'b1);
        @(posedge clk) ovr <= 1'b1;
        @(posedge clk) ovr <= 1'b0;
        wr8(8'h01, 8'h00);
        rd8(8'h1F, 8'h03);
        wr8(8'h01, 8'h08);
        rd8(8'h1F, 8'h02);
    endtask
    // Frames end without acknowledge in self test, and with and without it in normal mode.
    task automatic t_stest();
        wr8(8'h00, 8'h01);
        wr8(8'h00, 8'h05);
        wr8(8'h00, 8'h04);
        frame(1'b0);
        c1(txok, 1'b1);
        wr8(8'h00, 8'h01);
        wr8(8'h00, 8'h00);
        frame(1'b0);
        c1(txok, 1'b0);
        frame(1'b1);
        c1(txok, 1'b1);
    endtask
    task automatic t_sleep();
        w_on();
        wr8(8'h00, 8'h10);
        for (int i = 0; i < 10 && slp !== 1'b1; i++) cyc(1);
        c1(slp, 1'b1);
        @(posedge clk) dom <= 1'b1;
        for (int i = 0; i < 10 && wirq !== 1'b1; i++) cyc(1);
        c1(wirq, 1'b1);
        cyc(2);
        ck({6'h00, slp, rxen}, 8'h00);
        @(posedge clk) dom <= 1'b0;
        for (int i = 0; i < 100 && rxen !== 1'b1; i++) cyc(1);
        c1(rxen, 1'b1);
        @(posedge clk) irq <= 1'b1;
        wr8(8'h00, 8'h10);
        for (int i = 0; i < 10 && wirq !== 1'b1; i++) cyc(1);
        c1(wirq, 1'b1);
        cyc(3);
        c1(slp, 1'b0);
        @(posedge clk) irq <= 1'b0;
        // Sleep, then wake by clearing the sleep bit.
        wr8(8'h00, 8'h10);
        wr8(8'h00, 8'h00);
        cyc(1);
        c1(wirq, 1'b1);
    endtask
    task automatic t_boff();
        wr8(8'h00, 8'h01);
        wr8(8'h00, 8'h11);
        rd8(8'h00, 8'h01);
        wr8(8'h00, 8'h03);
        wr8(8'h00, 8'h02);
        ck({acken, erren, hold, txal}, 8'h02);
        wr8(8'h01, 8'h01);
        c1(txrq, 1'b0);
        wr8(8'h00, 8'h01);
        wr8(8'h00, 8'h00);
        w_on();
        @(posedge clk) boff <= 1'b1;
        cyc(2);
        c1(rmode, 1'b1);
        rd8(8'h1F, 8'h10);
        @(posedge clk) boff <= 1'b0;
        wr8(8'h00, 8'h00);
        cyc(1000);
        c1(bon, 1'b0);
        for (int i = 0; i < 2500 && bon !== 1'b1; i++) cyc(1);
        c1(bon, 1'b1);
    endtask
    task automatic print_verdict();
        if (fails == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // The whole run needs about 3100 cycles; allow over three times that.
    initial begin
        #50000;
        fails++;
        print_verdict();
    end
    initial begin
        {rstn, wr, rd, boff, irq, fdone, ack, ovr, dom, pol} = '0;
        {addr, wdata} = '0;
        ctxd = 1'b1;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        cyc(1);
        t_reg();
        t_loop();
        t_pol();
        t_cmd();
        t_stest();
        t_sleep();
        t_boff();
        print_verdict();
    end
endmodule
